// ### rtl/vtr_pkg.sv
package vtr_pkg;

   localparam int          NCH            = 14;

   // Register offsets
   localparam logic [7:0]  OFS_TXCTL      = 8'h01;
   localparam logic [7:0]  OFS_CMD        = 8'h03;
   localparam logic [7:0]  OFS_LINE       = 8'h04;
   localparam logic [7:0]  OFS_PROG       = 8'h05;
   localparam logic [7:0]  OFS_LERR       = 8'h07;
   localparam logic [7:0]  OFS_IRQ        = 8'h09;
   // Channel sets: base + 4 * channel, four registers each
   localparam logic [7:0]  OFS_CH_BASE    = 8'h10;
   localparam logic [7:0]  OFS_CH_END     = 8'h48;
   localparam logic [1:0]  CH_SUB_TAG     = 2'h0;
   localparam logic [1:0]  CH_SUB_TYPE    = 2'h1;
   localparam logic [1:0]  CH_SUB_PTR     = 2'h2;
   localparam logic [1:0]  CH_SUB_LEN     = 2'h3;

   // Command fields
   localparam int          CMD_ACT        = 0;
   localparam int          CMD_IDLE       = 1;
   localparam int          CMD_SLEEP      = 2;
   localparam int          CMD_REARB      = 3;
   // Channel length and status fields
   localparam int          LS_RECV        = 0;
   localparam int          LS_SENT        = 1;
   localparam int          LS_ABORT       = 2;
   localparam int          LS_LEN_LSB     = 3;
   // Channel type fields
   localparam int          TY_REQUEST     = 0;
   localparam int          TY_REPLY       = 1;
   // Line state, last error, interrupt flags
   localparam int          LINE_IDLE      = 0;
   localparam int          LINE_SLEEP     = 1;
   localparam int          LINE_ACTIVE    = 2;
   localparam int          LERR_CV        = 0;
   localparam int          LERR_ACK_FAULT_FLAG      = 1;
   localparam int          LERR_FRAME_CHECK_FAULT_FLAG      = 2;
   localparam int          IRQ_TXFAIL     = 0;
   localparam int          IRQ_TXOK       = 1;
   // Transmission progress fields
   localparam int          PROG_CH_LSB    = 0;
   localparam int          PROG_RTY_LSB   = 4;

   // Reset values
   localparam logic [3:0]  RST_MAX_RETRY  = 4'h0;
   localparam logic [2:0]  RST_CMD        = 3'h2;
   localparam logic [7:0]  RST_TAG        = 8'h00;
   localparam logic [1:0]  RST_TYPE       = 2'h0;
   localparam logic [6:0]  RST_PTR        = 7'h00;
   localparam logic [4:0]  RST_LEN        = 5'h00;
   localparam logic [7:0]  RST_RDATA      = 8'h00;

   typedef enum logic [1:0] {
      MODE_IDLE   = 2'b00,
      MODE_ACTIVE = 2'b01,
      MODE_SLEEP  = 2'b10
   } vtr_mode_t;

   typedef enum logic [1:0] {
      TX_SELECT = 2'b00,
      TX_START  = 2'b01,
      TX_WAIT   = 2'b10
   } vtr_tx_state_t;

   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } vtr_host_req_t;

   typedef struct packed {
      logic done;
      logic success;
      logic contention;
      logic code_violation;
      logic ack_fault;
      logic frame_check_fault;
   } vtr_attempt_t;

   typedef struct packed {
      logic       start;
      logic [3:0] chan;
      logic [6:0] ptr;
      logic [4:0] len;
      logic [7:0] tag;
   } vtr_tx_req_t;

endpackage : vtr_pkg

// ### rtl/vtr_retry_counter.sv
`timescale 1ns/10ps
module vtr_retry_counter (
   input  wire logic       clock,
   input  wire logic       rst,
   input  wire logic       load,
   input  wire logic       dec,
   input  wire logic [3:0] limit,
   output logic      [3:0] count,
   output logic      [3:0] retries_done,
   output logic            zero
);
   logic [3:0] count_reg;
   logic [3:0] limit_reg;

   // One counter shared by every channel; load takes the limit as it stands now
   always_ff @(posedge clock) begin
      if (rst) begin
         count_reg <= vtr_pkg::RST_MAX_RETRY;
         limit_reg <= vtr_pkg::RST_MAX_RETRY;
      end else if (load) begin
         count_reg <= limit;
         limit_reg <= limit;
      end else if (dec && count_reg != 4'h0) begin
         count_reg <= count_reg - 4'h1;
      end
   end

   assign count        = count_reg;
   assign zero         = (count_reg == 4'h0);
   assign retries_done = limit_reg - count_reg;
endmodule : vtr_retry_counter

// ### rtl/vtr_link_ctrl.sv
`timescale 1ns/10ps
module vtr_link_ctrl (
   input  wire logic                   clock,
   input  wire logic                   rst,
   input  wire vtr_pkg::vtr_host_req_t host_req,
   output logic                  [7:0] host_rdata,
   input  wire vtr_pkg::vtr_attempt_t  attempt,
   output vtr_pkg::vtr_tx_req_t        tx_req,
   output logic                        txd_oe,
   output logic                        rx_enable,
   output logic                        buffered_clock_out_en
);
   localparam int N = vtr_pkg::NCH;

   logic [7:0]           tag_reg  [N];
   logic [1:0]           type_reg [N];
   logic [6:0]           ptr_reg  [N];
   logic [4:0]           len_reg  [N];
   logic [N-1:0]         sent_reg;
   logic [N-1:0]         recv_reg;
   logic [N-1:0]         abort_reg;
   logic [N-1:0]         halt_reg;
   logic [3:0]           max_retry_field;
   logic [2:0]           cmd_reg;
   logic                 rearb_reg;
   logic [2:0]           lerr_reg;
   logic [1:0]           irq_reg;
   vtr_pkg::vtr_mode_t   mode_reg;
   vtr_pkg::vtr_tx_state_t state_reg;
   logic [3:0]           cur_reg;
   logic                 defer_valid_reg;
   logic [3:0]           defer_ch_reg;
   vtr_pkg::vtr_tx_req_t tx_req_reg;
   logic [7:0]           rdata_reg;
   logic                 oe_reg;
   logic                 clk_en_reg;

   logic [N-1:0]         ready;
   logic [N-1:0]         set_sent;
   logic [N-1:0]         abort_now;
   logic [4:0]           pick_any;
   logic [4:0]           pick_hi;
   logic [3:0]           link_ch;
   logic [3:0]           cnt_retries;
   logic                 cnt_zero;
   logic                 cnt_load;
   logic                 cnt_dec;
   logic                 attempt_end;
   logic                 cur_abort;
   logic                 ok_att;
   logic                 fail_att;
   logic                 give_up;
   logic                 cur_disabled;
   logic                 take_rearb;
   logic                 go_cmd;
   logic                 tx_busy;
   logic                 ch_hit;
   logic [3:0]           ch_idx;
   logic [1:0]           ch_sub;
   logic [7:0]           ch_off;

   // Producer types: data frame, reply request, deferred reply
   function automatic logic is_producer(input logic [1:0] ty, input logic sent,
                                        input logic recv);
      logic req;
      logic rep;
      req = ty[vtr_pkg::TY_REQUEST];
      rep = ty[vtr_pkg::TY_REPLY];
      is_producer = !sent && ((!rep && !req) || (rep && req && !recv) || (rep && !req && recv));
   endfunction : is_producer

   // Lowest set bit, found flag on top
   function automatic logic [4:0] lowest(input logic [N-1:0] vec);
      lowest = 5'h00;
      for (int i = N - 1; i >= 0; i--) begin
         if (vec[i]) begin
            lowest = {1'b1, 4'(i)};
         end
      end
   endfunction : lowest

   assign ch_off = host_req.addr - vtr_pkg::OFS_CH_BASE;
   assign ch_hit = host_req.addr >= vtr_pkg::OFS_CH_BASE && host_req.addr < vtr_pkg::OFS_CH_END;
   assign ch_idx = ch_off[5:2];
   assign ch_sub = ch_off[1:0];

   always_comb begin
      for (int i = 0; i < N; i++) begin
         ready[i] = is_producer(type_reg[i], sent_reg[i], recv_reg[i])
                    && !halt_reg[i] && !abort_reg[i];
      end
   end

   assign pick_any     = lowest(ready);
   assign pick_hi      = lowest(ready & N'((N'(1) << cur_reg) - N'(1)));
   assign attempt_end  = state_reg == vtr_pkg::TX_WAIT && attempt.done;
   assign cur_abort    = abort_reg[cur_reg];
   assign ok_att       = attempt_end && !cur_abort && attempt.success;
   assign fail_att     = attempt_end && !cur_abort && !attempt.success
                         && !attempt.contention;
   assign give_up      = fail_att && cnt_zero;
   assign cur_disabled = !is_producer(type_reg[cur_reg], sent_reg[cur_reg], recv_reg[cur_reg])
                         || halt_reg[cur_reg];
   assign take_rearb   = attempt_end && !cur_abort && !attempt.success && !give_up
                         && !cur_disabled && rearb_reg && pick_hi[4];
   assign go_cmd       = cmd_reg[vtr_pkg::CMD_ACT] && !cmd_reg[vtr_pkg::CMD_IDLE]
                         && !cmd_reg[vtr_pkg::CMD_SLEEP];
   assign tx_busy      = state_reg != vtr_pkg::TX_SELECT || defer_valid_reg;

   // Loaded whenever a channel is taken into service, including resume and preemption
   assign cnt_load = (state_reg == vtr_pkg::TX_SELECT && mode_reg == vtr_pkg::MODE_ACTIVE
                      && ((defer_valid_reg && ready[defer_ch_reg]) || (go_cmd && pick_any[4])))
                     || take_rearb;
   assign cnt_dec  = fail_att && !cnt_zero;

   vtr_retry_counter u_retry (
      .clock        (clock),
      .rst          (rst),
      .load         (cnt_load),
      .dec          (cnt_dec),
      .limit        (max_retry_field),
      .count        (),
      .retries_done (cnt_retries),
      .zero         (cnt_zero)
   );

   always_comb begin
      for (int i = 0; i < N; i++) begin
         abort_now[i] = abort_reg[i] && !(tx_busy && state_reg != vtr_pkg::TX_SELECT
                                          && cur_reg == 4'(i));
         set_sent[i]  = abort_now[i]
                        || (cur_reg == 4'(i) && (ok_att || (attempt_end && cur_abort)));
      end
   end

   // Channel register sets; a hardware set of the sent flag wins over a host write
   always_ff @(posedge clock) begin
      if (rst) begin
         sent_reg  <= '0;
         recv_reg  <= '0;
         abort_reg <= '0;
         halt_reg  <= '0;
         for (int i = 0; i < N; i++) begin
            tag_reg[i]  <= vtr_pkg::RST_TAG;
            type_reg[i] <= vtr_pkg::RST_TYPE;
            ptr_reg[i]  <= vtr_pkg::RST_PTR;
            len_reg[i]  <= vtr_pkg::RST_LEN;
         end
      end else begin
         for (int i = 0; i < N; i++) begin
            if (host_req.wr && ch_hit && ch_idx == 4'(i)) begin
               if (ch_sub == vtr_pkg::CH_SUB_TAG) begin
                  tag_reg[i] <= host_req.wdata;
               end else if (ch_sub == vtr_pkg::CH_SUB_TYPE) begin
                  type_reg[i] <= host_req.wdata[1:0];
               end else if (ch_sub == vtr_pkg::CH_SUB_PTR) begin
                  ptr_reg[i] <= host_req.wdata[6:0];
               end else begin
                  len_reg[i]  <= host_req.wdata[vtr_pkg::LS_LEN_LSB +: 5];
                  recv_reg[i] <= host_req.wdata[vtr_pkg::LS_RECV];
                  sent_reg[i] <= host_req.wdata[vtr_pkg::LS_SENT];
                  halt_reg[i] <= 1'b0;
                  // Abort on a channel already sent is dropped
                  if (host_req.wdata[vtr_pkg::LS_ABORT] && !sent_reg[i]) begin
                     abort_reg[i] <= 1'b1;
                  end
               end
            end
            if (set_sent[i]) begin
               sent_reg[i]  <= 1'b1;
               abort_reg[i] <= 1'b0;
            end
            if (give_up && cur_reg == 4'(i)) begin
               halt_reg[i] <= 1'b1;
            end
         end
      end
   end

   // Control registers
   always_ff @(posedge clock) begin
      if (rst) begin
         max_retry_field <= vtr_pkg::RST_MAX_RETRY;
         cmd_reg         <= vtr_pkg::RST_CMD;
      end else if (host_req.wr && host_req.addr == vtr_pkg::OFS_TXCTL) begin
         max_retry_field <= host_req.wdata[3:0];
      end else if (host_req.wr && host_req.addr == vtr_pkg::OFS_CMD) begin
         cmd_reg[vtr_pkg::CMD_ACT]   <= host_req.wdata[vtr_pkg::CMD_ACT];
         cmd_reg[vtr_pkg::CMD_IDLE]  <= host_req.wdata[vtr_pkg::CMD_IDLE];
         // Sleep stays until idle or activate is written without it
         cmd_reg[vtr_pkg::CMD_SLEEP] <= host_req.wdata[vtr_pkg::CMD_SLEEP]
            || (cmd_reg[vtr_pkg::CMD_SLEEP] && !host_req.wdata[vtr_pkg::CMD_ACT]
                && !host_req.wdata[vtr_pkg::CMD_IDLE]);
      end
   end

   // Rearbitrate is a command strobe held until a channel is preempted or service ends
   always_ff @(posedge clock) begin
      if (rst) begin
         rearb_reg <= 1'b0;
      end else if (host_req.wr && host_req.addr == vtr_pkg::OFS_CMD
                   && host_req.wdata[vtr_pkg::CMD_REARB]) begin
         rearb_reg <= 1'b1;
      end else if (take_rearb || state_reg == vtr_pkg::TX_SELECT) begin
         rearb_reg <= 1'b0;
      end
   end

   // Operating mode
   always_ff @(posedge clock) begin
      if (rst) begin
         mode_reg <= vtr_pkg::MODE_IDLE;
      end else if (cmd_reg[vtr_pkg::CMD_SLEEP]) begin
         mode_reg <= vtr_pkg::MODE_SLEEP;
      end else if (go_cmd) begin
         mode_reg <= vtr_pkg::MODE_ACTIVE;
      end else if (mode_reg == vtr_pkg::MODE_ACTIVE && tx_busy) begin
         mode_reg <= vtr_pkg::MODE_ACTIVE;
      end else begin
         mode_reg <= vtr_pkg::MODE_IDLE;
      end
   end

   // Transmit sequencing; sleep drops all internal transmit state at once
   always_ff @(posedge clock) begin
      if (rst || mode_reg != vtr_pkg::MODE_ACTIVE) begin
         state_reg       <= vtr_pkg::TX_SELECT;
         cur_reg         <= 4'h0;
         defer_valid_reg <= 1'b0;
         defer_ch_reg    <= 4'h0;
      end else begin
         case (state_reg)
            vtr_pkg::TX_SELECT: begin
               if (defer_valid_reg && ready[defer_ch_reg]) begin
                  cur_reg         <= defer_ch_reg;
                  defer_valid_reg <= 1'b0;
                  state_reg       <= vtr_pkg::TX_START;
               end else if (go_cmd && pick_any[4]) begin
                  cur_reg         <= pick_any[3:0];
                  defer_valid_reg <= 1'b0;
                  state_reg       <= vtr_pkg::TX_START;
               end else begin
                  defer_valid_reg <= 1'b0;
               end
            end
            vtr_pkg::TX_START: begin
               state_reg <= ready[cur_reg] ? vtr_pkg::TX_WAIT : vtr_pkg::TX_SELECT;
            end
            vtr_pkg::TX_WAIT: begin
               if (take_rearb) begin
                  defer_valid_reg <= 1'b1;
                  defer_ch_reg    <= cur_reg;
                  cur_reg         <= pick_hi[3:0];
                  state_reg       <= vtr_pkg::TX_START;
               end else if (attempt_end) begin
                  if (cur_abort || attempt.success || give_up || cur_disabled) begin
                     state_reg <= vtr_pkg::TX_SELECT;
                  end else begin
                     state_reg <= vtr_pkg::TX_START;
                  end
               end
            end
            default: begin
               state_reg <= vtr_pkg::TX_SELECT;
            end
         endcase
      end
   end

   // Request to the frame engine; linked channels borrow the target's mailbox
   assign link_ch = ptr_reg[cur_reg][3:0];
   always_ff @(posedge clock) begin
      if (rst) begin
         tx_req_reg <= '0;
      end else begin
         tx_req_reg.start <= state_reg == vtr_pkg::TX_START && ready[cur_reg]
                             && mode_reg == vtr_pkg::MODE_ACTIVE;
         tx_req_reg.chan  <= cur_reg;
         tx_req_reg.tag   <= tag_reg[cur_reg];
         if (len_reg[cur_reg] == 5'h00) begin
            tx_req_reg.ptr <= ptr_reg[link_ch];
            tx_req_reg.len <= len_reg[link_ch];
         end else begin
            tx_req_reg.ptr <= ptr_reg[cur_reg];
            tx_req_reg.len <= len_reg[cur_reg];
         end
      end
   end

   // Error cause and interrupt flags; a new event wins over a clear
   always_ff @(posedge clock) begin
      if (rst) begin
         lerr_reg <= 3'h0;
      end else if (fail_att) begin
         lerr_reg[vtr_pkg::LERR_CV]   <= attempt.code_violation;
         lerr_reg[vtr_pkg::LERR_ACK_FAULT_FLAG] <= attempt.ack_fault;
         lerr_reg[vtr_pkg::LERR_FRAME_CHECK_FAULT_FLAG] <= attempt.frame_check_fault;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         irq_reg <= 2'h0;
      end else begin
         if (host_req.wr && host_req.addr == vtr_pkg::OFS_IRQ) begin
            irq_reg <= irq_reg & ~host_req.wdata[1:0];
         end
         if (give_up) begin
            irq_reg[vtr_pkg::IRQ_TXFAIL] <= 1'b1;
         end
         if (ok_att) begin
            irq_reg[vtr_pkg::IRQ_TXOK] <= 1'b1;
         end
      end
   end

   // Line pins follow the mode
   always_ff @(posedge clock) begin
      if (rst) begin
         oe_reg     <= 1'b0;
         clk_en_reg <= 1'b1;
      end else begin
         oe_reg     <= mode_reg == vtr_pkg::MODE_ACTIVE;
         clk_en_reg <= mode_reg != vtr_pkg::MODE_SLEEP;
      end
   end

   // Register reads answer one cycle after the strobe, also in sleep
   always_ff @(posedge clock) begin
      if (rst) begin
         rdata_reg <= vtr_pkg::RST_RDATA;
      end else if (host_req.rd) begin
         rdata_reg <= 8'h00;
         if (host_req.addr == vtr_pkg::OFS_TXCTL) begin
            rdata_reg <= {4'h0, max_retry_field};
         end else if (host_req.addr == vtr_pkg::OFS_CMD) begin
            rdata_reg <= {5'h00, cmd_reg};
         end else if (host_req.addr == vtr_pkg::OFS_LINE) begin
            rdata_reg[vtr_pkg::LINE_IDLE]   <= mode_reg == vtr_pkg::MODE_IDLE;
            rdata_reg[vtr_pkg::LINE_SLEEP]  <= mode_reg == vtr_pkg::MODE_SLEEP;
            rdata_reg[vtr_pkg::LINE_ACTIVE] <= mode_reg == vtr_pkg::MODE_ACTIVE;
         end else if (host_req.addr == vtr_pkg::OFS_PROG) begin
            rdata_reg[vtr_pkg::PROG_RTY_LSB +: 4] <= cnt_retries;
            rdata_reg[vtr_pkg::PROG_CH_LSB +: 4]  <= cur_reg;
         end else if (host_req.addr == vtr_pkg::OFS_LERR) begin
            rdata_reg <= {5'h00, lerr_reg};
         end else if (host_req.addr == vtr_pkg::OFS_IRQ) begin
            rdata_reg <= {6'h00, irq_reg};
         end else if (ch_hit) begin
            if (ch_sub == vtr_pkg::CH_SUB_TAG) begin
               rdata_reg <= tag_reg[ch_idx];
            end else if (ch_sub == vtr_pkg::CH_SUB_TYPE) begin
               rdata_reg <= {6'h00, type_reg[ch_idx]};
            end else if (ch_sub == vtr_pkg::CH_SUB_PTR) begin
               rdata_reg <= {1'b0, ptr_reg[ch_idx]};
            end else begin
               rdata_reg <= {len_reg[ch_idx], abort_reg[ch_idx], sent_reg[ch_idx],
                             recv_reg[ch_idx]};
            end
         end
      end
   end

   assign host_rdata            = rdata_reg;
   assign tx_req                = tx_req_reg;
   assign txd_oe                = oe_reg;
   assign rx_enable             = oe_reg;
   assign buffered_clock_out_en = clk_en_reg;
endmodule : vtr_link_ctrl

// ### test/vtr_link_ctrl_monitor.sv
`timescale 1ns/10ps
module vtr_link_ctrl_monitor (
   input wire logic                   clock,
   input wire logic                   rst,
   input wire vtr_pkg::vtr_host_req_t host_req,
   input wire logic             [7:0] host_rdata,
   input wire vtr_pkg::vtr_attempt_t  attempt,
   input wire vtr_pkg::vtr_tx_req_t   tx_req,
   input wire logic                   txd_oe,
   input wire logic                   rx_enable,
   input wire logic                   buffered_clock_out_en
);
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   property p_rst; $fell(rst) |-> !txd_oe && buffered_clock_out_en && host_rdata == 8'h00;
   endproperty
   a_rst: assert property (p_rst) else $error("outputs wrong after reset");
   property p_rx; rx_enable == txd_oe; endproperty
   a_rx: assert property (p_rx) else $error("receive and transmit enables differ");
   property p_slp; !buffered_clock_out_en |-> !txd_oe; endproperty
   a_slp: assert property (p_slp) else $error("pin driven in sleep");
   property p_go; tx_req.start |-> txd_oe; endproperty
   a_go: assert property (p_go) else $error("start while not active");
   property p_one; tx_req.start |=> !tx_req.start; endproperty
   a_one: assert property (p_one) else $error("start longer than one cycle");
   property p_gap; attempt.done |=> !tx_req.start; endproperty
   a_gap: assert property (p_gap) else $error("restart too soon after done");
   property p_rearb; host_req.rd && host_req.addr == vtr_pkg::OFS_CMD |=> !host_rdata[3];
   endproperty
   a_rearb: assert property (p_rearb) else $error("rearbitrate bit reads set");
   property p_hold; !host_req.rd |=> $stable(host_rdata); endproperty
   a_hold: assert property (p_hold) else $error("read data moved without read");
   property p_sleep;
      host_req.wr && host_req.addr == vtr_pkg::OFS_CMD && host_req.wdata[2]
         |-> ##[2:4] !buffered_clock_out_en;
   endproperty
   a_sleep: assert property (p_sleep) else $error("sleep not entered");
   property p_wake;
      host_req.wr && host_req.addr == vtr_pkg::OFS_CMD && host_req.wdata[2:0] == 3'h2
         |-> ##[2:4] buffered_clock_out_en;
   endproperty
   a_wake: assert property (p_wake) else $error("sleep not left");
endmodule : vtr_link_ctrl_monitor
bind vtr_link_ctrl vtr_link_ctrl_monitor mon_u (.clock, .rst, .host_req, .host_rdata,
   .attempt, .tx_req, .txd_oe, .rx_enable, .buffered_clock_out_en);

// ### test/vtr_frame_model.sv
`timescale 1ns/10ps
module vtr_frame_model (
   input  wire logic                  clock,
   input  wire logic                  rst,
   input  wire vtr_pkg::vtr_tx_req_t  tx_req,
   input  wire vtr_pkg::vtr_attempt_t outcome,
   input  wire logic            [7:0] lat,
   output vtr_pkg::vtr_attempt_t      attempt
);
   logic [7:0] cnt_reg;
   logic       busy_reg;
   // Qualifiers are inverted outside done so a design that samples them late sees junk
   always_ff @(posedge clock) begin
      attempt <= {1'b0, ~outcome[4:0]};
      if (rst) begin
         busy_reg <= 1'b0;
      end else if (tx_req.start) begin
         busy_reg <= 1'b1;
         cnt_reg  <= lat;
      end else if (busy_reg && cnt_reg == 8'h00) begin
         busy_reg <= 1'b0;
         attempt  <= {1'b1, outcome[4:0]};
      end else begin
         cnt_reg <= cnt_reg - 8'h01;
      end
   end
endmodule : vtr_frame_model

// ### test/vtr_link_ctrl_tb_top.sv
`timescale 1ns/10ps
module vtr_link_ctrl_tb_top;
   logic                   clock = 1'b0;
   logic                   rst = 1'b1;
   logic             [7:0] host_rdata, lat = 8'h02;
   logic                   txd_oe, rx_enable, clk_en;
   vtr_pkg::vtr_host_req_t host_req = '0;
   vtr_pkg::vtr_attempt_t  attempt, outcome = '0;
   vtr_pkg::vtr_tx_req_t   tx_req;
   vtr_pkg::vtr_tx_req_t   starts[$];
   int                     errors = 0, n_tests = 0, cycles = 0;
   always #2 clock = ~clock;
   vtr_link_ctrl dut_u (.clock(clock), .rst(rst), .host_req(host_req), .host_rdata(host_rdata),
      .attempt(attempt), .tx_req(tx_req), .txd_oe(txd_oe), .rx_enable(rx_enable),
      .buffered_clock_out_en(clk_en));
   vtr_frame_model fe_u (.clock(clock), .rst(rst), .tx_req(tx_req), .outcome(outcome),
      .lat(lat), .attempt(attempt));
   always @(posedge clock) begin
      cycles++;
      if (tx_req.start === 1'b1) starts.push_back(tx_req);
      if (cycles == 20000) begin
         errors++;
         end_of_test();
      end
   end
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : end_of_test
   task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
      n_tests++;
      if (got !== exp) begin
         errors++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic wr(logic [7:0] a, logic [7:0] d);
      @(posedge clock);
      #1 host_req = {1'b1, 1'b0, a, d};
      @(posedge clock);
      #1 host_req = '0;
   endtask : wr
   task automatic rdc(logic [7:0] a, logic [7:0] exp, string what);
      @(posedge clock);
      #1 host_req = {1'b0, 1'b1, a, 8'h00};
      @(posedge clock);
      #1 host_req = '0;
      @(posedge clock);
      #1 if (what != "") chk(what, exp, host_rdata);
   endtask : rdc
   task automatic poll(logic [7:0] a, logic [7:0] m);
      rdc(a, 8'h00, "");
      for (int i = 0; i < 80 && (host_rdata & m) == 8'h00; i++) rdc(a, 8'h00, "");
   endtask : poll
   task automatic ws(int n);
      for (int i = 0; i < 300 && starts.size() < n; i++) @(posedge clock);
      #1;
   endtask : ws
   function automatic logic [7:0] ch(int c, int s);
      return 8'(8'h10 + c * 4 + s);
   endfunction : ch
   task automatic t_reset();
      chk("clock out", 8'h01, {7'h00, clk_en});
      rdc(vtr_pkg::OFS_CMD, 8'h02, "command");
      rdc(vtr_pkg::OFS_LINE, 8'h01, "line idle");
      rdc(8'hff, 8'h00, "unmapped");
      // Parked channels would otherwise link to channel 0 and transmit
      for (int c = 0; c < vtr_pkg::NCH; c++) wr(ch(c, 3), 8'h02);
      $display("test reset done");
   endtask : t_reset
   task automatic t_retry();
      wr(vtr_pkg::OFS_TXCTL, 8'h01);
      wr(ch(0, 2), 8'h10);
      wr(ch(0, 3), 8'h10);
      outcome = 6'b000010;
      starts.delete();
      wr(vtr_pkg::OFS_CMD, 8'h01);
      rdc(vtr_pkg::OFS_LINE, 8'h04, "line active");
      poll(vtr_pkg::OFS_IRQ, 8'h01);
      chk("attempts", 8'd2, 8'(starts.size()));
      rdc(vtr_pkg::OFS_LERR, 8'h02, "last error");
      rdc(vtr_pkg::OFS_PROG, 8'h10, "progress");
      chk("current channel", 8'h00, {4'h0, host_rdata[3:0]});
      rdc(ch(0, 3), 8'h10, "halted status");
      wr(vtr_pkg::OFS_IRQ, 8'h01);
      rdc(vtr_pkg::OFS_IRQ, 8'h00, "irq cleared");
      $display("test retry done");
   endtask : t_retry
   task automatic t_cont();
      wr(vtr_pkg::OFS_TXCTL, 8'h00);
      outcome = 6'b001000;
      starts.delete();
      wr(ch(1, 3), 8'h10);
      ws(4);
      outcome = 6'b010000;
      poll(vtr_pkg::OFS_IRQ, 8'h02);
      rdc(vtr_pkg::OFS_IRQ, 8'h02, "no failure");
      rdc(ch(1, 3), 8'h12, "sent status");
      wr(vtr_pkg::OFS_IRQ, 8'h02);
      $display("test contention done");
   endtask : t_cont
   task automatic t_abort();
      lat = 8'd40;
      outcome = 6'b000010;
      starts.delete();
      wr(ch(2, 3), 8'h10);
      ws(1);
      wr(ch(2, 3), 8'h14);
      repeat (60) @(posedge clock);
      rdc(ch(2, 3), 8'h12, "aborted status");
      rdc(vtr_pkg::OFS_IRQ, 8'h00, "abort irq");
      lat = 8'h02;
      $display("test abort done");
   endtask : t_abort
   // Channel 6 fails its first attempt; channel 5 preempts it, then 6 resumes with a reloaded counter
   task automatic t_rearb();
      lat = 8'd20;
      wr(vtr_pkg::OFS_TXCTL, 8'h01);
      starts.delete();
      wr(ch(6, 3), 8'h10);
      ws(1);
      wr(ch(5, 3), 8'h10);
      wr(vtr_pkg::OFS_CMD, 8'h09);
      rdc(vtr_pkg::OFS_CMD, 8'h01, "command");
      ws(5);
      chk("preempting channel", 8'h05, {4'h0, starts[1].chan});
      chk("resumed channel", 8'h06, {4'h0, starts[4].chan});
      $display("test rearbitrate done");
   endtask : t_rearb
   task automatic t_link();
      wr(vtr_pkg::OFS_CMD, 8'h02);
      repeat (8) @(posedge clock);
      wr(ch(4, 0), 8'hb4);
      wr(ch(4, 2), 8'h03);
      wr(ch(4, 3), 8'h00);
      wr(ch(3, 2), 8'h20);
      wr(ch(3, 3), 8'h20);
      outcome = 6'b010000;
      starts.delete();
      wr(vtr_pkg::OFS_CMD, 8'h01);
      ws(2);
      chk("first channel", 8'h03, {4'h0, starts[0].chan});
      chk("linked channel", 8'h04, {4'h0, starts[1].chan});
      chk("linked ptr", 8'h20, {1'b0, starts[1].ptr});
      chk("linked len", 8'h04, {3'h0, starts[1].len});
      chk("linked tag", 8'hb4, starts[1].tag);
      $display("test link done");
   endtask : t_link
   task automatic t_sleep();
      wr(vtr_pkg::OFS_CMD, 8'h04);
      repeat (4) @(posedge clock);
      #1;
      chk("sleep clock", 8'h00, {6'h00, clk_en, txd_oe});
      wr(vtr_pkg::OFS_TXCTL, 8'h05);
      rdc(vtr_pkg::OFS_TXCTL, 8'h05, "sleep access");
      rdc(vtr_pkg::OFS_LINE, 8'h02, "line sleep");
      wr(vtr_pkg::OFS_CMD, 8'h02);
      repeat (4) @(posedge clock);
      #1;
      chk("wake clock", 8'h01, {7'h00, clk_en});
      rdc(vtr_pkg::OFS_LINE, 8'h01, "line woken");
      $display("test sleep done");
   endtask : t_sleep
   initial begin
      repeat (16) @(posedge clock);
      #1 rst = 1'b0;
      t_reset();
      t_retry();
      t_cont();
      t_abort();
      t_rearb();
      t_link();
      t_sleep();
      end_of_test();
   end
endmodule : vtr_link_ctrl_tb_top
